// ==== cdec_decoder.sv ====
`timescale 1ns/10ps
// Overview of operation
// - bit 7 is most significant in every byte
// - segment register load and store move opcodes
// - exchange register/memory and with accumulator forms
// - port input, fixed or variable, byte/word
// - port output, fixed or variable, byte/word
// - table translate via base register into acc
// - load effective address, not memory contents
// - load full pointer with data/extra segment
// - four one-byte flag transfer opcodes
// - addition in three forms, immediate length
// - add with carry in three forms
// - subtraction in three forms
// - subtract with borrow in three forms
// - ascii and decimal adjust after addition
// - strings use source index (move, compare, load) and destination index (move, compare, scan, store)
// - short branch is signed 8-bit offset
// - far targets load code segment and pointer
// - escape presents coprocessor opcode and operand address
// - segment code 00 extra to 11 data
// - sign bit sign-extends single immediate byte
// - displacement presence and size from mode field
module cdec_decoder (
	input wire logic REF_CLK, // 40 MHz clock
	input wire logic RST, // asynchronous reset, active high
	input wire logic BYTE_VALID, // instruction queue offers a byte
	input wire logic [7:0] BYTE_DATA, // byte from the queue
	output logic BYTE_READY, // decoder takes the byte this cycle
	output logic DEC_VALID, // decoded instruction on offer
	input wire logic DEC_READY, // execution control accepts it
	output cdec_pkg::cdec_dec_s DEC_INFO // decoded instruction fields
);
	import cdec_pkg::*;

	// fields are taken in byte order
	// build is one spare cycle
	typedef enum logic [2:0] {
		st_opcode, st_modrm, st_disp, st_tail, st_build, st_done
	} cdec_state_e;

	cdec_state_e state_ff; // collector position
	cdec_state_e nxt_state; // its next value
	cdec_cls_s cls_in; // class of the byte on the queue
	cdec_cls_s cls_ff; // class of the held opcode
	logic [7:0] opcode_ff; // held opcode byte
	logic [7:0] modrm_ff; // held mode/reg/rm byte
	logic [15:0] disp_ff; // displacement, low byte first
	logic [2:0] cnt_ff; // bytes taken in the current field
	logic [7:0] tail_ff [TAIL_DEPTH]; // immediate, port or branch bytes
	cdec_dec_s dec_ff; // registered decoded instruction
	cdec_dec_s nxt_dec; // decoded value built from held bytes
	logic take; // a queue byte moves this cycle
	logic [2:0] modrm_in_disp; // displacement length of incoming modrm
	logic [2:0] modrm_ff_disp; // displacement length of held modrm

	// displacement bytes implied by the mode field
	function automatic logic [2:0] disp_len_of(input logic [1:0] mod_field);
		logic [2:0] len;
		len = LEN_ZERO;
		// mod 00 has no direct form here
		case (mod_field)
			MOD_DISP8: len = LEN_ONE;
			MOD_DISP16: len = LEN_TWO;
			default: len = LEN_ZERO;
		endcase
		return len;
	endfunction

	// segment register picked by the 2-bit code
	function automatic cdec_seg_e seg_of(input logic [1:0] code);
		cdec_seg_e seg;
		seg = extra_segment_reg;
		// code is bits 4:3 of byte two
		case (code)
			2'h0: seg = extra_segment_reg;
			2'h1: seg = code_segment_reg;
			2'h2: seg = stack_segment_reg;
			default: seg = data_segment_reg;
		endcase
		return seg;
	endfunction

	// one byte widened to 16 bits with its sign copied up
	function automatic logic [15:0] sext8(input logic [7:0] b);
		return {{8{b[SIGN_POS]}}, b};
	endfunction

	// pure logic on the queue byte
	// first-byte classification reaches every later state through cls_ff
	cdec_classify u_classify (
		.opcode(BYTE_DATA),
		.cls(cls_in)
	);

	// queue handshake; the decoder stalls the queue while an instruction waits
	// a byte offered in build or done
	// waits on the queue until taken
	assign BYTE_READY = (state_ff == st_opcode) || (state_ff == st_modrm)
		|| (state_ff == st_disp) || (state_ff == st_tail);
	assign take = BYTE_VALID && BYTE_READY;
	assign DEC_VALID = (state_ff == st_done);
	assign DEC_INFO = dec_ff;
	assign modrm_in_disp = disp_len_of(BYTE_DATA[MOD_HI:MOD_LO]);
	assign modrm_ff_disp = disp_len_of(modrm_ff[MOD_HI:MOD_LO]);

	// next state: opcode, optional modrm, optional displacement, optional tail
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			st_opcode: begin
				if (take) begin
					// one-byte forms go to build
					if (cls_in.has_modrm) begin
						nxt_state = st_modrm;
					end else if (cls_in.tail_len != LEN_ZERO) begin
						nxt_state = st_tail;
					end else begin
						nxt_state = st_build;
					end
				end
			end
			st_modrm: begin
				if (take) begin
					// mode sets the disp count
					if (modrm_in_disp != LEN_ZERO) begin
						nxt_state = st_disp;
					end else if (cls_ff.tail_len != LEN_ZERO) begin
						nxt_state = st_tail;
					end else begin
						nxt_state = st_build;
					end
				end
			end
			st_disp: begin
				// displacement always precedes immediate data
				if (take && (cnt_ff + 3'h1 == modrm_ff_disp)) begin
					nxt_state = (cls_ff.tail_len != LEN_ZERO) ? st_tail : st_build;
				end
			end
			st_tail: begin
				// count fixed by first byte
				if (take && (cnt_ff + 3'h1 == cls_ff.tail_len)) begin
					nxt_state = st_build;
				end
			end
			st_build: begin
				// one cycle to register fields
				nxt_state = st_done;
			end
			st_done: begin
				// wait for execution control
				if (DEC_READY) begin
					nxt_state = st_opcode;
				end
			end
			default: begin
				nxt_state = st_opcode;
			end
		endcase
	end

	// state register
	// async reset parks at opcode
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_ff <= st_opcode;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// byte counter, cleared whenever a new field begins
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cnt_ff <= LEN_ZERO;
		end else if (nxt_state != state_ff) begin
			cnt_ff <= LEN_ZERO;
		end else if (take) begin
			cnt_ff <= cnt_ff + 3'h1;
		end
	end

	// opcode and its classification, caught with the first byte
	// kept so no later reclassify
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			opcode_ff <= BYTE_RESET;
			cls_ff <= '0;
		end else if (take && (state_ff == st_opcode)) begin
			opcode_ff <= BYTE_DATA;
			cls_ff <= cls_in;
		end
	end

	// mode/reg/rm byte; cleared per opcode so forms without one read as zero
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			modrm_ff <= BYTE_RESET;
		end else if (take && (state_ff == st_opcode)) begin
			modrm_ff <= BYTE_RESET;
		end else if (take && (state_ff == st_modrm)) begin
			modrm_ff <= BYTE_DATA;
		end
	end

	// displacement, kept unsigned; the address unit decides how to extend it
	// low byte first, then high
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			disp_ff <= 16'h0000;
		end else if (take && (state_ff == st_opcode)) begin
			disp_ff <= 16'h0000;
		end else if (take && (state_ff == st_disp)) begin
			if (cnt_ff == LEN_ZERO) begin
				disp_ff[7:0] <= BYTE_DATA;
			end else begin
				disp_ff[15:8] <= BYTE_DATA;
			end
		end
	end

	// tail bytes, one register per entry, filled in arrival order
	// entry index = tail count
	generate
		for (genvar i = 0; i < TAIL_DEPTH; i++) begin : g_tail
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					tail_ff[i] <= BYTE_RESET;
				end else if (take && (state_ff == st_opcode)) begin
					tail_ff[i] <= BYTE_RESET;
				end else if (take && (state_ff == st_tail) && (cnt_ff == 3'(i))) begin
					tail_ff[i] <= BYTE_DATA;
				end
			end
		end
	endgenerate

	// field extraction from the held bytes; runs during st_build
	// unused fields stay zero
	always_comb begin
		nxt_dec = '0;
		nxt_dec.op = cls_ff.op;
		nxt_dec.word = cls_ff.word;
		nxt_dec.to_reg = cls_ff.to_reg;
		nxt_dec.has_modrm = cls_ff.has_modrm;
		nxt_dec.src_index_used = cls_ff.src_index_used;
		nxt_dec.dst_index_used = cls_ff.dst_index_used;
		nxt_dec.seg = extra_segment_reg;
		nxt_dec.length = 3'h1 + {2'h0, cls_ff.has_modrm} + cls_ff.tail_len;
		// operand fields of the second byte
		if (cls_ff.has_modrm) begin
			nxt_dec.mod_field = modrm_ff[MOD_HI:MOD_LO];
			nxt_dec.reg_field = modrm_ff[REG_HI:REG_LO];
			nxt_dec.rm_field = modrm_ff[RM_HI:RM_LO];
			nxt_dec.mem_operand = (modrm_ff[MOD_HI:MOD_LO] != MOD_REGISTER);
			nxt_dec.disp_len = modrm_ff_disp;
			nxt_dec.disp = disp_ff;
			nxt_dec.length = nxt_dec.length + modrm_ff_disp;
		end
		// immediate group: the reg field names the arithmetic
		if (cls_ff.op == imm_group_op) begin
			case (modrm_ff[REG_HI:REG_LO])
				SUBOP_ADD: nxt_dec.op = add_op;
				SUBOP_CARRY: nxt_dec.op = add_carry_op;
				SUBOP_BORROW: nxt_dec.op = subtract_borrow_op;
				SUBOP_SUBTRACT: nxt_dec.op = subtract_op;
				default: nxt_dec.op = unknown_op; // other group members are not decoded here
			endcase
		end
		// segment moves: the bit above the code must be zero
		if ((cls_ff.op == move_seg_load_op) || (cls_ff.op == move_seg_store_op)) begin
			nxt_dec.seg = seg_of(modrm_ff[SEG_HI:SEG_LO]);
			if (modrm_ff[SEG_ZERO_POS]) begin
				nxt_dec.op = unknown_op;
			end
		end
		// pointer loads name the segment register they fill
		if (cls_ff.op == load_pointer_data_seg_op) begin
			nxt_dec.seg = data_segment_reg;
		end else if (cls_ff.op == load_pointer_extra_seg_op) begin
			nxt_dec.seg = extra_segment_reg;
		end
		// one-byte exchange: register sits in the opcode's low bits
		if (cls_ff.op == exchange_acc_op) begin
			nxt_dec.reg_field = opcode_ff[RM_HI:RM_LO];
		end
		// translate addresses its table through the base register
		if (cls_ff.op == table_translate_op) begin
			nxt_dec.base_reg_addr = 1'b1;
		end
		// escape: six opcode bits for the coprocessor, operand address only
		if (cls_ff.op == coprocessor_escape_op) begin
			nxt_dec.escape_code = {opcode_ff[RM_HI:RM_LO], modrm_ff[REG_HI:REG_LO]};
		end
		// trailing bytes by kind
		case (cls_ff.tail_kind)
			tail_imm: begin
				// second byte only for words
				if (cls_ff.tail_len == LEN_TWO) begin
					nxt_dec.imm = {tail_ff[1], tail_ff[0]};
				end else if (cls_ff.sign_ext) begin
					nxt_dec.imm = sext8(tail_ff[0]);
				end else begin
					nxt_dec.imm = {8'h00, tail_ff[0]};
				end
			end
			tail_port: begin
				nxt_dec.port_fixed = 1'b1;
				nxt_dec.port = tail_ff[0];
			end
			tail_branch: begin
				// short offsets sign-extend
				if (cls_ff.tail_len == LEN_ONE) begin
					nxt_dec.branch_offset = sext8(tail_ff[0]);
				end else begin
					nxt_dec.branch_offset = {tail_ff[1], tail_ff[0]};
				end
				if (cls_ff.tail_len == LEN_FOUR) begin
					nxt_dec.far_target = 1'b1;
					nxt_dec.new_code_seg = {tail_ff[3], tail_ff[2]};
				end
			end
			default: begin
				// forms with no trailing bytes
				nxt_dec.imm = 16'h0000;
			end
		endcase
	end

	// decoded output register, loaded once per instruction
	// holds through done
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			dec_ff <= '0;
		end else if (state_ff == st_build) begin
			dec_ff <= nxt_dec;
		end
	end

endmodule

// ==== cdec_pkg.sv ====
package cdec_pkg;

	// byte layout: bit 7 is the leftmost, most significant position
	localparam int W_POS = 0;
	localparam int D_POS = 1;
	localparam int S_POS = 1;
	localparam int MOD_HI = 7;
	localparam int MOD_LO = 6;
	localparam int REG_HI = 5;
	localparam int REG_LO = 3;
	localparam int RM_HI = 2;
	localparam int RM_LO = 0;
	localparam int SEG_ZERO_POS = 5;
	localparam int SEG_HI = 4;
	localparam int SEG_LO = 3;
	localparam int SIGN_POS = 7;

	// opcode masks: exact, width bit free, direction and width free, register free
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_W = 8'hFE;
	localparam logic [7:0] MASK_DW = 8'hFC;
	localparam logic [7:0] MASK_REG = 8'hF8;

	// opcode values, compared under the masks above
	localparam logic [7:0] OPC_SEG_LOAD = 8'h8E;
	localparam logic [7:0] OPC_SEG_STORE = 8'h8C;
	localparam logic [7:0] OPC_EXCH_RM = 8'h86;
	localparam logic [7:0] OPC_EXCH_ACC = 8'h90;
	localparam logic [7:0] OPC_IN_FIXED = 8'hE4;
	localparam logic [7:0] OPC_IN_VAR = 8'hEC;
	localparam logic [7:0] OPC_OUT_FIXED = 8'hE6;
	localparam logic [7:0] OPC_OUT_VAR = 8'hEE;
	localparam logic [7:0] OPC_TRANSLATE = 8'hD7;
	localparam logic [7:0] OPC_LOAD_EA = 8'h8D;
	localparam logic [7:0] OPC_LOAD_PTR_DATA = 8'hC5;
	localparam logic [7:0] OPC_LOAD_PTR_EXTRA = 8'hC4;
	localparam logic [7:0] OPC_FLAGS_TO_HIGH = 8'h9F;
	localparam logic [7:0] OPC_HIGH_TO_FLAGS = 8'h9E;
	localparam logic [7:0] OPC_PUSH_FLAGS = 8'h9C;
	localparam logic [7:0] OPC_POP_FLAGS = 8'h9D;
	localparam logic [7:0] OPC_ADD_RM = 8'h00;
	localparam logic [7:0] OPC_ADD_ACC = 8'h04;
	localparam logic [7:0] OPC_IMM_GROUP = 8'h80;
	localparam logic [7:0] OPC_CARRY_RM = 8'h10;
	localparam logic [7:0] OPC_CARRY_ACC = 8'h14;
	localparam logic [7:0] OPC_SUBTRACT_RM = 8'h28;
	localparam logic [7:0] OPC_SUBTRACT_ACC = 8'h2C;
	localparam logic [7:0] OPC_BORROW_RM = 8'h18;
	localparam logic [7:0] OPC_BORROW_ACC = 8'h1C;
	localparam logic [7:0] OPC_ASCII_ADJ = 8'h37;
	localparam logic [7:0] OPC_DECIMAL_ADJ = 8'h27;
	localparam logic [7:0] OPC_STR_MOVE = 8'hA4;
	localparam logic [7:0] OPC_STR_COMPARE = 8'hA6;
	localparam logic [7:0] OPC_STR_SCAN = 8'hAE;
	localparam logic [7:0] OPC_STR_LOAD = 8'hAC;
	localparam logic [7:0] OPC_STR_STORE = 8'hAA;
	localparam logic [7:0] OPC_SHORT_JUMP = 8'hEB;
	localparam logic [7:0] OPC_NEAR_JUMP = 8'hE9;
	localparam logic [7:0] OPC_NEAR_CALL = 8'hE8;
	localparam logic [7:0] OPC_FAR_JUMP = 8'hEA;
	localparam logic [7:0] OPC_FAR_CALL = 8'h9A;
	localparam logic [7:0] OPC_ESCAPE = 8'hD8;

	// immediate group sub-opcodes held in the reg field
	localparam logic [2:0] SUBOP_ADD = 3'h0;
	localparam logic [2:0] SUBOP_CARRY = 3'h2;
	localparam logic [2:0] SUBOP_BORROW = 3'h3;
	localparam logic [2:0] SUBOP_SUBTRACT = 3'h5;

	// mode field values
	localparam logic [1:0] MOD_NO_DISP = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_REGISTER = 2'h3;

	// byte counts of trailing fields
	localparam logic [2:0] LEN_ZERO = 3'h0;
	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_TWO = 3'h2;
	localparam logic [2:0] LEN_FOUR = 3'h4;
	localparam int TAIL_DEPTH = 4;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [4:0] {
		unknown_op, imm_group_op, move_seg_load_op, move_seg_store_op, exchange_op,
		exchange_acc_op, in_port_op, out_port_op, table_translate_op,
		load_effective_address_op, load_pointer_data_seg_op, load_pointer_extra_seg_op,
		flags_to_high_acc_op, high_acc_to_flags_op, push_flags_op, pop_flags_op,
		add_op, add_carry_op, subtract_op, subtract_borrow_op, ascii_add_adjust_op,
		decimal_add_adjust_op, string_op, short_branch_op, near_branch_op,
		far_branch_op, coprocessor_escape_op
	} cdec_op_e;

	typedef enum logic [1:0] {
		extra_segment_reg, code_segment_reg, stack_segment_reg, data_segment_reg
	} cdec_seg_e;

	typedef enum logic [1:0] {tail_none, tail_imm, tail_port, tail_branch} cdec_tail_e;

	// what the first byte alone tells
	typedef struct packed {
		cdec_op_e op;
		logic has_modrm;
		cdec_tail_e tail_kind;
		logic [2:0] tail_len;
		logic word;
		logic to_reg;
		logic sign_ext;
		logic src_index_used;
		logic dst_index_used;
	} cdec_cls_s;

	// one fully decoded instruction
	typedef struct packed {
		cdec_op_e op;
		logic word;
		logic to_reg;
		logic has_modrm;
		logic [1:0] mod_field;
		logic [2:0] reg_field;
		logic [2:0] rm_field;
		logic mem_operand;
		cdec_seg_e seg;
		logic [2:0] disp_len;
		logic [15:0] disp;
		logic [15:0] imm;
		logic port_fixed;
		logic [7:0] port;
		logic src_index_used;
		logic dst_index_used;
		logic base_reg_addr;
		logic far_target;
		logic [15:0] branch_offset;
		logic [15:0] new_code_seg;
		logic [5:0] escape_code;
		logic [2:0] length;
	} cdec_dec_s;

endpackage

// ==== cdec_classify.sv ====
`timescale 1ns/10ps
module cdec_classify (
	input wire logic [7:0] opcode, // first byte of an instruction
	output cdec_pkg::cdec_cls_s cls // what follows it and what it does
);
	import cdec_pkg::*;

	// opcode equals value on the bits the mask keeps
	function automatic logic hit(input logic [7:0] op, input logic [7:0] val,
			input logic [7:0] mask);
		hit = ((op & mask) == val);
	endfunction

	// priority chain; masked forms never overlap so order is only for reading
	always_comb begin
		cls = '0;
		cls.op = unknown_op;
		cls.word = opcode[W_POS];
		cls.to_reg = opcode[D_POS];
		if (hit(opcode, OPC_SEG_LOAD, MASK_FULL)) begin
			cls.op = move_seg_load_op;
			cls.has_modrm = 1'b1;
			cls.word = 1'b1;
			cls.to_reg = 1'b1;
		end else if (hit(opcode, OPC_SEG_STORE, MASK_FULL)) begin
			cls.op = move_seg_store_op;
			cls.has_modrm = 1'b1;
			cls.word = 1'b1;
			cls.to_reg = 1'b0;
		end else if (hit(opcode, OPC_LOAD_EA, MASK_FULL)) begin
			cls.op = load_effective_address_op;
			cls.has_modrm = 1'b1;
			cls.word = 1'b1;
			cls.to_reg = 1'b1;
		end else if (hit(opcode, OPC_EXCH_RM, MASK_W)) begin
			cls.op = exchange_op;
			cls.has_modrm = 1'b1;
		end else if (hit(opcode, OPC_EXCH_ACC, MASK_REG)) begin
			cls.op = exchange_acc_op;
			cls.word = 1'b1;
		end else if (hit(opcode, OPC_IN_FIXED, MASK_W) || hit(opcode, OPC_OUT_FIXED, MASK_W)) begin
			cls.op = hit(opcode, OPC_IN_FIXED, MASK_W) ? in_port_op : out_port_op;
			cls.tail_kind = tail_port;
			cls.tail_len = LEN_ONE;
		end else if (hit(opcode, OPC_IN_VAR, MASK_W) || hit(opcode, OPC_OUT_VAR, MASK_W)) begin
			cls.op = hit(opcode, OPC_IN_VAR, MASK_W) ? in_port_op : out_port_op;
		end else if (hit(opcode, OPC_TRANSLATE, MASK_FULL)) begin
			cls.op = table_translate_op;
			cls.word = 1'b0;
		end else if (hit(opcode, OPC_LOAD_PTR_DATA, MASK_FULL)
				|| hit(opcode, OPC_LOAD_PTR_EXTRA, MASK_FULL)) begin
			cls.op = hit(opcode, OPC_LOAD_PTR_DATA, MASK_FULL) ? load_pointer_data_seg_op
				: load_pointer_extra_seg_op;
			cls.has_modrm = 1'b1;
			cls.word = 1'b1;
			cls.to_reg = 1'b1;
		end else if (hit(opcode, OPC_FLAGS_TO_HIGH, MASK_FULL)) begin
			cls.op = flags_to_high_acc_op;
		end else if (hit(opcode, OPC_HIGH_TO_FLAGS, MASK_FULL)) begin
			cls.op = high_acc_to_flags_op;
		end else if (hit(opcode, OPC_PUSH_FLAGS, MASK_FULL)) begin
			cls.op = push_flags_op;
		end else if (hit(opcode, OPC_POP_FLAGS, MASK_FULL)) begin
			cls.op = pop_flags_op;
		end else if (hit(opcode, OPC_ADD_RM, MASK_DW) || hit(opcode, OPC_CARRY_RM, MASK_DW)
				|| hit(opcode, OPC_SUBTRACT_RM, MASK_DW) || hit(opcode, OPC_BORROW_RM, MASK_DW)) begin
			cls.has_modrm = 1'b1;
			if (hit(opcode, OPC_ADD_RM, MASK_DW)) begin
				cls.op = add_op;
			end else if (hit(opcode, OPC_CARRY_RM, MASK_DW)) begin
				cls.op = add_carry_op;
			end else if (hit(opcode, OPC_SUBTRACT_RM, MASK_DW)) begin
				cls.op = subtract_op;
			end else begin
				cls.op = subtract_borrow_op;
			end
		end else if (hit(opcode, OPC_ADD_ACC, MASK_W) || hit(opcode, OPC_CARRY_ACC, MASK_W)
				|| hit(opcode, OPC_SUBTRACT_ACC, MASK_W) || hit(opcode, OPC_BORROW_ACC, MASK_W)) begin
			cls.tail_kind = tail_imm;
			cls.tail_len = opcode[W_POS] ? LEN_TWO : LEN_ONE;
			cls.to_reg = 1'b1;
			if (hit(opcode, OPC_ADD_ACC, MASK_W)) begin
				cls.op = add_op;
			end else if (hit(opcode, OPC_CARRY_ACC, MASK_W)) begin
				cls.op = add_carry_op;
			end else if (hit(opcode, OPC_SUBTRACT_ACC, MASK_W)) begin
				cls.op = subtract_op;
			end else begin
				cls.op = subtract_borrow_op;
			end
		end else if (hit(opcode, OPC_IMM_GROUP, MASK_DW)) begin
			cls.op = imm_group_op;
			cls.has_modrm = 1'b1;
			cls.tail_kind = tail_imm;
			cls.sign_ext = opcode[S_POS];
			cls.to_reg = 1'b0;
			cls.tail_len = ({opcode[S_POS], opcode[W_POS]} == 2'h1) ? LEN_TWO : LEN_ONE;
		end else if (hit(opcode, OPC_ASCII_ADJ, MASK_FULL) || hit(opcode, OPC_DECIMAL_ADJ, MASK_FULL)) begin
			cls.op = hit(opcode, OPC_ASCII_ADJ, MASK_FULL) ? ascii_add_adjust_op
				: decimal_add_adjust_op;
			cls.word = 1'b0;
		end else if (hit(opcode, OPC_STR_MOVE, MASK_W) || hit(opcode, OPC_STR_COMPARE, MASK_W)
				|| hit(opcode, OPC_STR_LOAD, MASK_W)) begin
			cls.op = string_op;
			cls.src_index_used = 1'b1;
			cls.dst_index_used = !hit(opcode, OPC_STR_LOAD, MASK_W);
		end else if (hit(opcode, OPC_STR_SCAN, MASK_W) || hit(opcode, OPC_STR_STORE, MASK_W)) begin
			cls.op = string_op;
			cls.dst_index_used = 1'b1;
		end else if (hit(opcode, OPC_SHORT_JUMP, MASK_FULL)) begin
			cls.op = short_branch_op;
			cls.tail_kind = tail_branch;
			cls.tail_len = LEN_ONE;
		end else if (hit(opcode, OPC_NEAR_JUMP, MASK_FULL) || hit(opcode, OPC_NEAR_CALL, MASK_FULL)) begin
			cls.op = near_branch_op;
			cls.tail_kind = tail_branch;
			cls.tail_len = LEN_TWO;
		end else if (hit(opcode, OPC_FAR_JUMP, MASK_FULL) || hit(opcode, OPC_FAR_CALL, MASK_FULL)) begin
			cls.op = far_branch_op;
			cls.tail_kind = tail_branch;
			cls.tail_len = LEN_FOUR;
		end else if (hit(opcode, OPC_ESCAPE, MASK_REG)) begin
			cls.op = coprocessor_escape_op;
			cls.has_modrm = 1'b1;
		end
	end

endmodule

// ==== cdec_decoder_properties.sv ====
`timescale 1ns/10ps
module cdec_decoder_properties import cdec_pkg::*; (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic BYTE_VALID,
	input wire logic [7:0] BYTE_DATA,
	input wire logic BYTE_READY,
	input wire logic DEC_VALID,
	input wire logic DEC_READY,
	input wire cdec_dec_s DEC_INFO
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// one build cycle between last byte and result
	a_result_latency: assert property ($fell(BYTE_READY) |-> !DEC_VALID ##1 DEC_VALID)
		else $error("result late");
	a_result_holds: assert property (DEC_VALID && !DEC_READY |=> DEC_VALID && $stable(DEC_INFO))
		else $error("result moved");
	a_accept_frees: assert property (DEC_VALID && DEC_READY |=> BYTE_READY && !DEC_VALID)
		else $error("queue not reopened");
	// the queue stays shut while a result waits
	a_queue_shut: assert property (DEC_VALID |-> !BYTE_READY)
		else $error("queue open");
	a_mem_by_mode: assert property (DEC_VALID && DEC_INFO.has_modrm |->
		DEC_INFO.mem_operand == (DEC_INFO.mod_field != MOD_REGISTER)) else $error("mem flag");
	a_disp_by_mode: assert property (DEC_VALID && DEC_INFO.has_modrm |->
		DEC_INFO.disp_len == (DEC_INFO.mod_field == MOD_DISP8 ? LEN_ONE :
		DEC_INFO.mod_field == MOD_DISP16 ? LEN_TWO : LEN_ZERO)) else $error("disp len");
	a_seg_code: assert property (DEC_VALID && DEC_INFO.op == move_seg_load_op |->
		2'(DEC_INFO.seg) == DEC_INFO.reg_field[1:0]) else $error("seg code");
	a_far_target: assert property (DEC_VALID && DEC_INFO.op == far_branch_op |->
		DEC_INFO.far_target && DEC_INFO.length == 3'h5) else $error("far target");
	a_short_branch: assert property (DEC_VALID && DEC_INFO.op == short_branch_op |->
		DEC_INFO.length == LEN_TWO && !DEC_INFO.far_target) else $error("short branch");
	// refused byte, stalled result, far branch
	c_refused: cover property (BYTE_VALID && !BYTE_READY);
	c_stall: cover property (DEC_VALID && !DEC_READY);
	c_far: cover property (DEC_VALID && DEC_INFO.op == far_branch_op);
endmodule

// ==== cdec_decoder_test.sv ====
`timescale 1ns/10ps
module cdec_decoder_test;
	import cdec_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic byte_valid = 1'b0;
	logic [7:0] byte_data = 8'h00;
	logic dec_ready = 1'b0;
	logic byte_ready;
	logic dec_valid;
	cdec_dec_s info; // result port
	cdec_dec_s d; // last accepted result
	int fail_count = 0;
	int tests_run = 0;
	cdec_decoder u_dut (.REF_CLK(ref_clk), .RST(rst), .BYTE_VALID(byte_valid),
		.BYTE_DATA(byte_data), .BYTE_READY(byte_ready), .DEC_VALID(dec_valid),
		.DEC_READY(dec_ready), .DEC_INFO(info));
	// 40 MHz clock
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a hang counts as a mismatch and ends the run
	task automatic guard(input int n);
		if (n > 40) begin
			check(32'h0, 32'h1);
			final_report();
		end
	endtask
	// bytes back to back, each held until taken
	task automatic send(input logic [7:0] b[$]);
		int n;
		foreach (b[i]) begin
			byte_valid = 1'b1;
			byte_data = b[i];
			for (n = 0; byte_ready !== 1'b1; n++) begin
				guard(n);
				tick();
			end
			tick();
		end
		byte_valid = 1'b0;
	endtask
	// result taken on a single accepting edge
	task automatic get(output cdec_dec_s r);
		int n;
		for (n = 0; dec_valid !== 1'b1; n++) begin
			guard(n);
			tick();
		end
		r = info;
		dec_ready = 1'b1;
		tick();
		dec_ready = 1'b0;
	endtask
	task automatic dec(input logic [7:0] b[$], input cdec_op_e op, input logic [2:0] len);
		send(b);
		get(d);
		check(d.op, op);
		check(d.length, len);
	endtask
	localparam logic [7:0] ONE_OPC [10] = '{8'hD7, 8'h9F, 8'h9E, 8'h9C, 8'h9D, 8'h37,
		8'h27, 8'hEC, 8'hEF, 8'hA4};
	localparam cdec_op_e ONE_OP [10] = '{table_translate_op, flags_to_high_acc_op,
		high_acc_to_flags_op, push_flags_op, pop_flags_op, ascii_add_adjust_op,
		decimal_add_adjust_op, in_port_op, out_port_op, string_op};
	task automatic t_one_byte();
		for (int i = 0; i < 10; i++) begin
			dec('{ONE_OPC[i]}, ONE_OP[i], LEN_ONE);
			check(d.base_reg_addr, i == 0);
			check(d.src_index_used, i == 9);
		end
		check(d.dst_index_used, 1'b1);
		dec('{8'hAF}, string_op, LEN_ONE);
		check({d.src_index_used, d.dst_index_used}, 2'h1);
		dec('{8'h95}, exchange_acc_op, LEN_ONE);
		check(d.reg_field, 3'h5);
		$display("one-byte forms done");
	endtask
	task automatic t_modrm();
		dec('{8'h8E, 8'h5A, 8'h7F}, move_seg_load_op, 3'h3);
		check({d.seg, d.disp}, {data_segment_reg, 16'h007F});
		dec('{8'h8C, 8'hC0}, move_seg_store_op, LEN_TWO);
		check({d.seg, d.mem_operand}, {extra_segment_reg, 1'b0});
		dec('{8'h8C, 8'hE0}, unknown_op, LEN_TWO);
		dec('{8'h8D, 8'h94, 8'h34, 8'h12}, load_effective_address_op, LEN_FOUR);
		check(d.disp, 16'h1234);
		dec('{8'h03, 8'hC1}, add_op, LEN_TWO);
		check({d.to_reg, d.word}, 2'h3);
		dec('{8'h28, 8'h01}, subtract_op, LEN_TWO);
		check({d.to_reg, d.word, d.mem_operand}, 3'h1);
		dec('{8'h12, 8'hC0}, add_carry_op, LEN_TWO);
		dec('{8'h19, 8'h00}, subtract_borrow_op, LEN_TWO);
		dec('{8'hC4, 8'h06}, load_pointer_extra_seg_op, LEN_TWO);
		dec('{8'hC5, 8'h4F, 8'h10}, load_pointer_data_seg_op, 3'h3);
		dec('{8'h87, 8'hD8}, exchange_op, LEN_TWO);
		dec('{8'hDB, 8'hE8}, coprocessor_escape_op, LEN_TWO);
		check(d.escape_code, 6'h1D);
		$display("modrm forms done");
	endtask
	task automatic t_imm();
		dec('{8'h81, 8'hC0, 8'h34, 8'h12}, add_op, LEN_FOUR);
		check(d.imm, 16'h1234);
		dec('{8'h83, 8'hE8, 8'h80}, subtract_op, 3'h3);
		check(d.imm, 16'hFF80);
		dec('{8'h80, 8'hD0, 8'h05}, add_carry_op, 3'h3);
		dec('{8'h82, 8'h5F, 8'h01, 8'h07}, subtract_borrow_op, LEN_FOUR);
		check(d.imm, 16'h0007);
		dec('{8'h80, 8'hC8, 8'h01}, unknown_op, 3'h3);
		dec('{8'h05, 8'h34, 8'h12}, add_op, 3'h3);
		dec('{8'h14, 8'h05}, add_carry_op, LEN_TWO);
		dec('{8'h2D, 8'h00, 8'h80}, subtract_op, 3'h3);
		dec('{8'h1C, 8'hFF}, subtract_borrow_op, LEN_TWO);
		dec('{8'hE4, 8'h60}, in_port_op, LEN_TWO);
		check({d.port_fixed, d.word, d.port}, 10'h260);
		dec('{8'hE7, 8'h61}, out_port_op, LEN_TWO);
		check({d.port_fixed, d.word, d.port}, 10'h361);
		dec('{8'hEB, 8'h80}, short_branch_op, LEN_TWO);
		check(d.branch_offset, 16'hFF80);
		dec('{8'hE8, 8'h00, 8'h10}, near_branch_op, 3'h3);
		check(d.branch_offset, 16'h1000);
		dec('{8'hEA, 8'h34, 8'h12, 8'h00, 8'hF0}, far_branch_op, 3'h5);
		check({d.far_target, d.new_code_seg}, 17'h1F000);
		dec('{8'h9A, 8'h78, 8'h56, 8'h34, 8'h12}, far_branch_op, 3'h5);
		check({d.branch_offset, d.new_code_seg}, 32'h56781234);
		$display("immediate, port and branch forms done");
	endtask
	// next opcode offered while a result is stalled must wait
	task automatic t_stall();
		cdec_dec_s q;
		send('{8'h9C});
		fork
			send('{8'h9D});
			begin
				repeat (6) tick();
				get(q);
			end
		join
		check(q.op, push_flags_op);
		get(d);
		check(d.op, pop_flags_op);
		$display("stall done");
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_one_byte();
		t_modrm();
		t_imm();
		t_stall();
		final_report();
	end
endmodule
bind cdec_decoder cdec_decoder_properties u_props (.REF_CLK(REF_CLK), .RST(RST),
	.BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA), .BYTE_READY(BYTE_READY),
	.DEC_VALID(DEC_VALID), .DEC_READY(DEC_READY), .DEC_INFO(DEC_INFO));
